// >>> common/fdr_pkg.sv
// Shared constants and types for the floppy host register block.
// Assumes a 40 MHz system clock and an 8-bit register port.
package fdr_pkg;
    localparam int AW = 3;
    localparam logic [2:0] ADDR_DTYPE = 3'h1;
    localparam logic [2:0] ADDR_DOC = 3'h2;
    localparam logic [2:0] ADDR_MSR = 3'h4;
    localparam logic [2:0] ADDR_DATA = 3'h5;
    localparam logic [2:0] ADDR_DIN_TRS = 3'h7;
    localparam int DOC_SEL_BIT = 0;
    localparam int DOC_FRST_BIT = 2;
    localparam int DOC_IEN_BIT = 3;
    localparam int DOC_MA_BIT = 4;
    localparam int DOC_MB_BIT = 5;
    localparam logic [7:0] DOC_MASK = 8'h3D;
    localparam logic [7:0] DOC_RST = 8'h00;
    localparam logic [1:0] TRS_RST = 2'h0;
    localparam logic [1:0] RATE_500 = 2'h0;
    localparam logic [1:0] RATE_300 = 2'h1;
    localparam logic [1:0] RATE_RSVD = 2'h3;
    localparam int DATA_HEAD_BIT = 2;
    localparam logic [3:0] OP_SENSE = 4'h4;
    localparam logic [3:0] OP_WRITE = 4'h5;
    localparam logic [3:0] OP_SEEK = 4'hF;
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_PROT = 8'h20;
    localparam logic [7:0] RES_NOMOTOR = 8'h40;
    localparam logic [7:0] RES_INVALID = 8'h80;
    localparam int SYNC_W = 7;
    localparam int CLK_MHZ = 40;
    localparam int WP_8M_NS = 150;
    localparam int WP_48M_NS = 208;
    localparam int WP_4M_NS = 250;
    localparam int WP_8M_CYC = (WP_8M_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_48M_CYC = (WP_48M_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_4M_CYC = (WP_4M_NS * CLK_MHZ + 999) / 1000;
    localparam int CELL_500_NS = 2000;
    localparam int CELL_300_NS = 3333;
    localparam int CELL_250_NS = 4000;
    localparam int CELL_500_CYC = CELL_500_NS * CLK_MHZ / 1000;
    localparam int CELL_300_CYC = CELL_300_NS * CLK_MHZ / 1000;
    localparam int CELL_250_CYC = CELL_250_NS * CLK_MHZ / 1000;
    localparam int STEP_ACT_US = 5;
    localparam int STEP_CYC_US = 33;
    localparam int DIR_SET_US = 1;
    localparam int STEP_ACT_CYC = STEP_ACT_US * CLK_MHZ;
    localparam int STEP_CYC_CYC = STEP_CYC_US * CLK_MHZ;
    localparam int DIR_SET_CYC = DIR_SET_US * CLK_MHZ;
    localparam int MOTOR_HD_MS = 1000;
    localparam int MOTOR_DD_MS = 750;
    localparam int MOTOR_HD_CYC = MOTOR_HD_MS * 1000 * CLK_MHZ;
    localparam int MOTOR_DD_CYC = MOTOR_DD_MS * 1000 * CLK_MHZ;
    typedef enum logic [2:0] {
        ST_CMD, ST_SETTLE, ST_DIR, ST_STEP, ST_WR_WAIT, ST_WR_BIT, ST_RESULT
    } fdr_state_t;
endpackage : fdr_pkg

// >>> design/fdr_pulse_gen.sv
// Fixed-width pulse generator used for step and write pulses.
// Assumes width is at least one and start is a clk_sys pulse.
`timescale 1ns/1ps
`default_nettype none
module fdr_pulse_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] width,
    output logic pulse,
    output logic done
);
    logic [7:0] cnt_r;
    // High for exactly width cycles; a start during a pulse is ignored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse <= 1'b0;
            cnt_r <= 8'h00;
        end else if (start && !pulse) begin
            pulse <= 1'b1;
            cnt_r <= width - 8'h01;
        end else if (pulse) begin
            if (cnt_r == 8'h00) begin
                pulse <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
    // Last high cycle, the trailing edge follows
    assign done = pulse && (cnt_r == 8'h00);
endmodule : fdr_pulse_gen
`default_nettype wire

// >>> design/fdr_sync.sv
// Two-flop synchroniser bank for the drive-side inputs.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module fdr_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [fdr_pkg::SYNC_W-1:0] d_in,
    output logic [fdr_pkg::SYNC_W-1:0] d_out
);
    import fdr_pkg::*;
    genvar g;
    // One two-stage chain per input bit
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_bit
            logic meta_r;
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r <= 1'b0;
                    d_out[g] <= 1'b0;
                end else begin
                    meta_r <= d_in[g];
                    d_out[g] <= meta_r;
                end
            end
        end
    endgenerate
endmodule : fdr_sync
`default_nettype wire

// >>> design/fdr_top.sv
// Host register bank and drive-side port of a two-drive floppy controller.
// Assumes a single 40 MHz clock, a one-cycle strobe register port and
// drive inputs that are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module fdr_top #(
    parameter int SETTLE_HD_CYC = fdr_pkg::MOTOR_HD_CYC,
    parameter int SETTLE_DD_CYC = fdr_pkg::MOTOR_DD_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [fdr_pkg::AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq_req,
    output logic dma_req,
    output logic head_sel,
    output logic step_out,
    output logic dir_out,
    output logic wgate_out,
    output logic wdata_out,
    output logic reduced_write,
    output logic drive_a_sel,
    output logic drive_b_sel,
    output logic motor_a_on,
    output logic motor_b_on,
    input wire logic read_data_n,
    input wire logic index_n,
    input wire logic track0_n,
    input wire logic wprot_n,
    input wire logic disk_change,
    input wire logic density_a,
    input wire logic density_b
);
    import fdr_pkg::*;

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [SYNC_W-1:0] sync_v;
    logic rd_s, idx_s, trk0_s, wprot_s, dchg_s;
    logic [1:0] dens_s;
    logic rd_prev_r, idx_prev_r, rd_fall, idx_fall;
    logic rd_seen_r, idx_seen_r;
    logic [7:0] doc_r;
    logic [1:0] trs_r;
    fdr_state_t state_r;
    logic [7:0] prm_r [3];
    logic [1:0] prm_cnt_r;
    logic [7:0] res_r;
    logic [6:0] cyl_r [2];
    logic [6:0] tgt_r;
    logic [10:0] tmr_r;
    logic [7:0] wbyte_r, cell_r, wr_left_r;
    logic [2:0] bit_cnt_r;
    logic drv_r, head_r, dir_r, op_wr_r;
    logic [1:0] motor, settled;
    logic [3:0] op;
    logic [7:0] byte1;
    logic last, host_ready, dir_host, data_wr, data_rd, sense_go;
    logic step_go, step_p, step_done, wr_go, wp_p, wgate, en;
    logic seek_act, busy;
    logic [7:0] msr, wp_w, cell_p, wp_len_r;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    fdr_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d_in({density_b, density_a, disk_change, wprot_n, track0_n, index_n, read_data_n}),
        .d_out(sync_v)
    );
    assign {dens_s, dchg_s, wprot_s, trk0_s, idx_s, rd_s} = sync_v;

    // Falling edges of read and index pulses, caught as sticky status
    assign rd_fall = rd_prev_r && !rd_s;
    assign idx_fall = idx_prev_r && !idx_s;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_prev_r <= 1'b0; // Synchroniser resets low, so no false fall
            idx_prev_r <= 1'b0;
            rd_seen_r <= 1'b0;
            idx_seen_r <= 1'b0;
        end else begin
            rd_prev_r <= rd_s;
            idx_prev_r <= idx_s;
            rd_seen_r <= rd_fall || (rd_seen_r && !sense_go);
            idx_seen_r <= idx_fall || (idx_seen_r && !sense_go);
        end
    end

    // Drive control and rate registers, reserved bits dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            doc_r <= DOC_RST;
            trs_r <= TRS_RST;
        end else if (reg_wr && reg_addr == ADDR_DOC) begin
            doc_r <= reg_wdata & DOC_MASK;
        end else if (reg_wr && reg_addr == ADDR_DIN_TRS && reg_wdata[1:0] != RATE_RSVD) begin
            trs_r <= reg_wdata[1:0];
        end
    end
    assign en = doc_r[DOC_FRST_BIT];
    assign motor = {doc_r[DOC_MB_BIT], doc_r[DOC_MA_BIT]};

    // Rate-dependent write pulse width and bit cell length
    always_comb begin
        unique case (trs_r)
            RATE_500: begin
                wp_w = 8'(WP_8M_CYC);
                cell_p = 8'(CELL_500_CYC);
            end
            RATE_300: begin
                wp_w = 8'(WP_48M_CYC);
                cell_p = 8'(CELL_300_CYC);
            end
            default: begin
                wp_w = 8'(WP_4M_CYC);
                cell_p = 8'(CELL_250_CYC);
            end
        endcase
    end

    // Motor settle timer per drive
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_mot
            logic [25:0] cnt_r;
            logic done_r;
            logic [25:0] lim;
            assign lim = dens_s[g] ? 26'(SETTLE_HD_CYC - 1) : 26'(SETTLE_DD_CYC - 1);
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r <= 26'h0000000;
                    done_r <= 1'b0;
                end else if (!motor[g]) begin
                    cnt_r <= 26'h0000000;
                    done_r <= 1'b0;
                end else if (!done_r) begin
                    done_r <= (cnt_r >= lim);
                    cnt_r <= cnt_r + 26'h0000001;
                end
            end
            assign settled[g] = done_r;
        end
    endgenerate

    // Command decode of the byte being written
    assign op = (prm_cnt_r == 2'h0) ? reg_wdata[3:0] : prm_r[0][3:0];
    assign byte1 = (prm_cnt_r == 2'h1) ? reg_wdata : prm_r[1];
    always_comb begin
        case (op)
            OP_SEEK, OP_WRITE: last = (prm_cnt_r == 2'h2);
            OP_SENSE: last = (prm_cnt_r == 2'h1);
            default: last = 1'b1;
        endcase
    end

    // Host handshake and status flags
    assign host_ready = (state_r == ST_CMD) || (state_r == ST_WR_WAIT) || (state_r == ST_RESULT);
    assign dir_host = (state_r == ST_RESULT);
    assign data_wr = reg_wr && reg_addr == ADDR_DATA && host_ready && !dir_host;
    assign data_rd = reg_rd && reg_addr == ADDR_DATA && dir_host;
    assign sense_go = en && data_wr && state_r == ST_CMD && last && op == OP_SENSE;
    assign busy = op_wr_r && (state_r == ST_SETTLE || state_r == ST_WR_WAIT || state_r == ST_WR_BIT);
    assign seek_act = !op_wr_r && (state_r == ST_SETTLE || state_r == ST_DIR || state_r == ST_STEP);
    assign msr = {host_ready, dir_host, !doc_r[DOC_IEN_BIT], busy, 2'b00,
                  seek_act && drv_r, seek_act && !drv_r};
    assign irq_req = doc_r[DOC_IEN_BIT] && dir_host;
    assign dma_req = doc_r[DOC_IEN_BIT] && state_r == ST_WR_WAIT;
    assign wgate = (state_r == ST_WR_WAIT) || (state_r == ST_WR_BIT);
    assign step_go = (state_r == ST_DIR) && (tmr_r == 11'(DIR_SET_CYC - 1));
    assign wr_go = (state_r == ST_WR_BIT) && (cell_r == 8'h00) && wbyte_r[7];

    // Command engine: intake, seek, write serialiser, result
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_CMD;
            prm_cnt_r <= 2'h0;
            prm_r <= '{default: 8'h00};
            res_r <= RES_OK;
            cyl_r <= '{default: 7'h00};
            tgt_r <= 7'h00;
            tmr_r <= 11'h000;
            wbyte_r <= 8'h00;
            cell_r <= 8'h00;
            wr_left_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            drv_r <= 1'b0;
            head_r <= 1'b0;
            dir_r <= 1'b0;
            op_wr_r <= 1'b0;
        end else if (!en) begin
            state_r <= ST_CMD;
            prm_cnt_r <= 2'h0;
            op_wr_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_CMD: if (data_wr) begin
                    prm_r[prm_cnt_r] <= reg_wdata;
                    prm_cnt_r <= last ? 2'h0 : prm_cnt_r + 2'h1;
                    if (last) begin
                        drv_r <= doc_r[DOC_SEL_BIT];
                        head_r <= byte1[DATA_HEAD_BIT];
                        op_wr_r <= (op == OP_WRITE);
                        tgt_r <= reg_wdata[6:0];
                        wr_left_r <= reg_wdata;
                        if (op == OP_SEEK || op == OP_WRITE) begin
                            state_r <= ST_SETTLE;
                        end else begin
                            state_r <= ST_RESULT;
                        end
                        if (op == OP_SENSE) begin
                            res_r <= {!wprot_s, !trk0_s, idx_seen_r || idx_fall,
                                      rd_seen_r || rd_fall, settled[doc_r[DOC_SEL_BIT]],
                                      byte1[DATA_HEAD_BIT], 1'b0, doc_r[DOC_SEL_BIT]};
                        end else begin
                            res_r <= RES_INVALID;
                        end
                    end
                end
                ST_SETTLE: begin
                    tmr_r <= 11'h000;
                    if (!motor[drv_r]) begin
                        res_r <= RES_NOMOTOR;
                        state_r <= ST_RESULT;
                    end else if (!settled[drv_r]) begin
                        state_r <= ST_SETTLE;
                    end else if (op_wr_r) begin
                        res_r <= wprot_s ? RES_OK : RES_PROT;
                        state_r <= (!wprot_s || wr_left_r == 8'h00) ? ST_RESULT : ST_WR_WAIT;
                    end else if (cyl_r[drv_r] == tgt_r) begin
                        res_r <= RES_OK;
                        state_r <= ST_RESULT;
                    end else begin
                        dir_r <= (tgt_r < cyl_r[drv_r]);
                        state_r <= ST_DIR;
                    end
                end
                ST_DIR: begin
                    tmr_r <= step_go ? 11'h000 : tmr_r + 11'h001;
                    if (step_go) begin
                        state_r <= ST_STEP;
                    end
                end
                ST_STEP: begin
                    tmr_r <= tmr_r + 11'h001;
                    if (step_done) begin
                        if (dir_r && !trk0_s) begin
                            cyl_r[drv_r] <= 7'h00;
                        end else if (dir_r) begin
                            cyl_r[drv_r] <= cyl_r[drv_r] - 7'h01;
                        end else begin
                            cyl_r[drv_r] <= cyl_r[drv_r] + 7'h01;
                        end
                    end
                    if (tmr_r == 11'(STEP_CYC_CYC - 1)) begin
                        tmr_r <= 11'h000;
                        if (cyl_r[drv_r] == tgt_r || (dir_r && !trk0_s)) begin
                            res_r <= RES_OK;
                            state_r <= ST_RESULT;
                        end else begin
                            state_r <= ST_DIR;
                        end
                    end
                end
                ST_WR_WAIT: if (data_wr) begin
                    wbyte_r <= reg_wdata;
                    bit_cnt_r <= 3'h0;
                    cell_r <= 8'h00;
                    state_r <= ST_WR_BIT;
                end
                ST_WR_BIT: begin
                    cell_r <= cell_r + 8'h01;
                    if (cell_r == cell_p - 8'h01) begin
                        cell_r <= 8'h00;
                        wbyte_r <= {wbyte_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            wr_left_r <= wr_left_r - 8'h01;
                            state_r <= (wr_left_r == 8'h01) ? ST_RESULT : ST_WR_WAIT;
                        end
                    end
                end
                ST_RESULT: if (data_rd) begin
                    state_r <= ST_CMD;
                end
            endcase
        end
    end

    fdr_pulse_gen u_step (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(step_go),
        .width(8'(STEP_ACT_CYC)),
        .pulse(step_p),
        .done(step_done)
    );

    fdr_pulse_gen u_wpulse (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(wr_go),
        .width(wp_w),
        .pulse(wp_p),
        .done()
    );

    // Registered drive outputs, all but the motor enables gated off while no drive is enabled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            drive_a_sel <= 1'b0;
            drive_b_sel <= 1'b0;
            motor_a_on <= 1'b0;
            motor_b_on <= 1'b0;
            head_sel <= 1'b0;
            step_out <= 1'b0;
            dir_out <= 1'b0;
            wgate_out <= 1'b0;
            wdata_out <= 1'b0;
            reduced_write <= 1'b0;
        end else begin
            drive_a_sel <= en && !doc_r[DOC_SEL_BIT];
            drive_b_sel <= en && doc_r[DOC_SEL_BIT];
            motor_a_on <= motor[0];
            motor_b_on <= motor[1];
            head_sel <= en && head_r;
            step_out <= en && step_p;
            dir_out <= en && dir_r;
            wgate_out <= en && wgate;
            wdata_out <= en && wgate && wp_p;
            reduced_write <= en && !dens_s[doc_r[DOC_SEL_BIT]];
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (!reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                ADDR_DTYPE: reg_rdata <= {6'h00, dens_s};
                ADDR_MSR: reg_rdata <= msr;
                ADDR_DATA: reg_rdata <= dir_host ? res_r : 8'h00;
                ADDR_DIN_TRS: reg_rdata <= {dchg_s, 7'h00};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Helper: length of the current write pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_len_r <= 8'h00;
        end else begin
            wp_len_r <= wdata_out ? wp_len_r + 8'h01 : 8'h00;
        end
    end

    property p_wp_width;
        @(posedge clk_sys) disable iff (!rst_n) $fell(wdata_out) |-> wp_len_r == wp_w;
    endproperty
    a_wp_width: assert property (p_wp_width) else $error("write pulse width wrong");

    property p_step_settled;
        @(posedge clk_sys) disable iff (!rst_n) $rose(step_out) |-> settled[drv_r];
    endproperty
    a_step_settled: assert property (p_step_settled) else $error("step before settle");

    property p_desel;
        @(posedge clk_sys) disable iff (!rst_n)
            !drive_a_sel && !drive_b_sel |-> !step_out && !wgate_out && !head_sel && !dir_out;
    endproperty
    a_desel: assert property (p_desel) else $error("output active while deselected");

    property p_rwc;
        @(posedge clk_sys) disable iff (!rst_n) drive_b_sel |-> reduced_write == !$past(dens_s[1]);
    endproperty
    a_rwc: assert property (p_rwc) else $error("reduced write level wrong");

    property p_doc_wo;
        @(posedge clk_sys) disable iff (!rst_n) reg_rd && reg_addr == ADDR_DOC |=> reg_rdata == 8'h00;
    endproperty
    a_doc_wo: assert property (p_doc_wo) else $error("control register readable");

    property p_motor;
        @(posedge clk_sys) disable iff (!rst_n)
            reg_wr && reg_addr == ADDR_DOC |-> ##2 motor_b_on == $past(reg_wdata[5], 2);
    endproperty
    a_motor: assert property (p_motor) else $error("motor B not following bit");

    property p_func_rst;
        @(posedge clk_sys) disable iff (!rst_n)
            reg_wr && reg_addr == ADDR_DOC && !reg_wdata[2] |-> ##2 !drive_a_sel && !drive_b_sel;
    endproperty
    a_func_rst: assert property (p_func_rst) else $error("select active in reset");

    property p_dsel;
        @(posedge clk_sys) disable iff (!rst_n)
            reg_wr && reg_addr == ADDR_DOC && reg_wdata[2] |-> ##2 drive_b_sel == $past(reg_wdata[0], 2);
    endproperty
    a_dsel: assert property (p_dsel) else $error("drive select wrong");

    property p_dtype;
        @(posedge clk_sys) disable iff (!rst_n)
            reg_rd && reg_addr == ADDR_DTYPE |=> reg_rdata == {6'h00, $past(dens_s)};
    endproperty
    a_dtype: assert property (p_dtype) else $error("drive type read wrong");
endmodule : fdr_top
`default_nettype wire

// >>> tb/fdr_drive_model.sv
// Drive mechanism model: head position, index and read pulses.
// Assumes one mechanism answers whichever select is active.
`timescale 1ns/1ps
`default_nettype none
module fdr_drive_model (
    input wire logic clk_sys,
    input wire logic step_out,
    input wire logic dir_out,
    input wire logic sel,
    input wire logic protect,
    output logic read_data_n,
    output logic index_n,
    output logic track0_n,
    output logic wprot_n
);
    int cyl = 0;
    int t = 0;
    logic sq = 0;
    // Head moves on the trailing edge of step, seen at the settled falling edge
    always @(negedge clk_sys) begin
        sq <= step_out;
        t <= (t + 1) % 3000;
        if (sel && sq && !step_out) cyl <= dir_out ? (cyl > 0 ? cyl - 1 : 0) : cyl + 1;
    end
    // Lines idle high while deselected
    assign index_n = !(sel && t < 8);
    assign read_data_n = !(sel && t % 400 < 6);
    assign track0_n = !(sel && cyl == 0);
    assign wprot_n = !(sel && protect);
endmodule : fdr_drive_model
`default_nettype wire

// >>> tb/fdr_top_tb.sv
// Bench for fdr_top: registers, drive outputs, seek, write.
// Assumes fdr_drive_model on the drive side.
`timescale 1ns/1ps
`default_nettype none
module fdr_top_tb;
import fdr_pkg::*;
logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, prot = 0, sq = 0, wq = 0, dq = 0, hq = 0;
logic [2:0] reg_addr = 0;
logic [7:0] reg_wdata = 0, d;
wire logic [7:0] reg_rdata;
wire logic step_out, dir_out, wgate_out, wdata_out, head_sel, reduced_write, drive_a_sel, drive_b_sel;
wire logic motor_a_on, motor_b_on, rdn, idxn, t0n, wpn, irq_req, dma_req;
int error_cnt = 0, compares = 0, cyc = 0, steps = 0, pul = 0, wl = 0, ww = 0, ng = 0;
initial forever #12.5 clk_sys = ~clk_sys;
fdr_top #(.SETTLE_HD_CYC(50), .SETTLE_DD_CYC(40)) u_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq_req, .dma_req, .head_sel, .step_out, .dir_out, .wgate_out, .wdata_out,
    .reduced_write, .drive_a_sel, .drive_b_sel, .motor_a_on, .motor_b_on, .read_data_n(rdn), .index_n(idxn),
    .track0_n(t0n), .wprot_n(wpn), .disk_change(1'b1), .density_a(1'b1), .density_b(1'b0));
fdr_drive_model u_drv (.clk_sys, .step_out, .dir_out, .sel(drive_a_sel | drive_b_sel), .protect(prot),
    .read_data_n(rdn), .index_n(idxn), .track0_n(t0n), .wprot_n(wpn));
// Counts steps and write pulses where outputs are settled, timeout
always @(negedge clk_sys) begin
    cyc++;
    sq <= step_out;
    wq <= wdata_out;
    if (step_out && !sq) steps++;
    if (step_out && !sq) dq <= dir_out;
    if (wdata_out) wl++;
    if (wdata_out && !wq) pul++;
    if (wdata_out && !wgate_out) ng++;
    if (wdata_out && !wq) hq = head_sel;
    if (!wdata_out && wq) ww = wl;
    if (!wdata_out) wl = 0;
    if (cyc == 60000) begin
        error_cnt++;
        finish_test;
    end
end
task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
        error_cnt++;
        $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
endtask : chk
task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk_sys);
    reg_wr <= 0;
endtask : wr
task rd(input logic [2:0] a);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    reg_rd <= 0;
    @(negedge clk_sys);
    d = reg_rdata;
endtask : rd
task waitv(input logic [7:0] m, input logic [7:0] v);
    do rd(ADDR_MSR); while ((d & m) !== v);
endtask : waitv
task send(input logic [7:0] v);
    waitv(8'hC0, 8'h80);
    wr(ADDR_DATA, v);
endtask : send
task od(input logic [7:0] v);
    repeat (2) @(negedge clk_sys);
    chk("drv", {3'h0, motor_b_on, motor_a_on, drive_b_sel, drive_a_sel, reduced_write}, v);
endtask : od
task t_seek(input logic [7:0] c, input logic [7:0] e);
    steps = 0;
    send(8'h0F);
    send(8'h00);
    send(c);
    rd(ADDR_MSR);
    chk("sbusy", d, 8'h21);
    waitv(8'hC0, 8'hC0);
    rd(ADDR_DATA);
    chk("seek", d, RES_OK);
    chk("steps", {steps[6:0], dq}, e);
endtask : t_seek
task t_wr(input logic [1:0] r, input logic [7:0] w, input logic [7:0] res);
    {pul, ww, ng, hq} = 0;
    wr(ADDR_DIN_TRS, {6'h0, r});
    send(8'h05);
    send(8'h04);
    send(8'h01);
    if (res == RES_OK) begin
        waitv(8'hD0, 8'h90);
        chk("wbusy", d, 8'h90);
        chk("dma", {7'h0, dma_req}, 8'h01);
        send(8'hA5);
    end
    waitv(8'hC0, 8'hC0);
    chk("irq", {7'h0, irq_req}, 8'h01);
    rd(ADDR_DATA);
    chk("wres", d, res);
    chk("irq0", {7'h0, irq_req}, 8'h00);
    chk("wpul", {pul[3:0], hq, ng[2:0]}, res == RES_OK ? 8'h48 : 8'h00);
    chk("wwid", ww[7:0], w);
endtask : t_wr
task finish_test;
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask : finish_test
initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1;
    repeat (5) @(posedge clk_sys);
    od(8'h00);
    rd(ADDR_DTYPE); chk("dtype", d, 8'h01);
    wr(ADDR_DTYPE, 8'hFF); rd(ADDR_DTYPE); chk("dtro", d, 8'h01);
    rd(ADDR_DIN_TRS); chk("din", d, 8'h80);
    wr(ADDR_DOC, 8'h10); od(8'h08);
    wr(ADDR_DOC, 8'h3D); od(8'h1D);
    rd(ADDR_DOC); chk("docwo", d, 8'h00);
    rd(ADDR_MSR); chk("pio", d & 8'h20, 8'h00);
    wr(ADDR_DOC, 8'h14); od(8'h0A);
    rd(3'h0); chk("unmap", d, 8'h00);
    t_seek(8'h03, 8'h06);
    t_seek(8'h00, 8'h07);
    wr(ADDR_DOC, 8'h1C);
    t_wr(2'h0, 8'd6, RES_OK);
    t_wr(2'h2, 8'd10, RES_OK);
    t_wr(2'h1, 8'd9, RES_OK);
    t_wr(2'h3, 8'd9, RES_OK);
    prot = 1;
    t_wr(2'h0, 8'd0, RES_PROT);
    send(8'h04); send(8'h00); waitv(8'hC0, 8'hC0);
    rd(ADDR_DATA); chk("sense", d, 8'hF8);
    send(8'h01); waitv(8'hC0, 8'hC0);
    rd(ADDR_DATA); chk("inval", d, RES_INVALID);
    wr(ADDR_DOC, 8'h04); send(8'h0F); send(8'h00); send(8'h05); waitv(8'hC0, 8'hC0);
    rd(ADDR_DATA); chk("nomot", d, RES_NOMOTOR);
    finish_test;
end
endmodule : fdr_top_tb
`default_nettype wire
